/* hdl/fdi_target.sv */
`timescale 1ns/1ps
module fdi_target
    import fdi_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Host select and chain
    input  wire logic        sel_n,
    input  wire logic        chain_enable_in,
    // Command, address and data-in strobes
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        addr_valid,
    input  wire logic [7:0]  addr_byte,
    input  wire logic        din_valid,
    input  wire logic [7:0]  din_byte,
    input  wire logic        rd_strobe,
    // Data out
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    // Status
    output logic             ready_busy_n,
    output logic             chain_enable_out,
    output logic             vol_selected,
    output logic             vol_appointed,
    output logic             seq_mode
);

    // ========================================================================
    // State
    // ========================================================================
    fdi_regs_t  q;
    fdi_regs_t  d;
    logic [7:0] rom_byte;
    fdi_mode_t  eff_mode;
    logic       responsive;
    logic       accept_reset;

    fdi_param_rom u_rom (
        .idx  (q.ptr),
        .data (rom_byte)
    );

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        d          = q;
        d.dout_vld = 1'b0;
        eff_mode   = q.mode;
        // An appointed target answers only while its volume is selected.
        responsive = q.appointed ? q.selected : chain_enable_in;
        accept_reset = 1'b0;
        if (q.mode == MODE_NONE && cmd_valid && !sel_n) begin
            eff_mode = (cmd_byte == CMD_STATUS) ? MODE_SEQ : MODE_PAR;
        end
        if (q.appointed) begin
            accept_reset = q.selected;
        end else begin
            accept_reset = (eff_mode == MODE_PAR) || chain_enable_in;
        end

        case (q.state)
            ST_IDLE: begin
                if (cmd_valid && !sel_n) begin
                    d.mode = eff_mode;
                    d.cmd  = cmd_byte;
                    case (cmd_byte)
                        CMD_STATUS: begin
                            if (q.mode == MODE_NONE || responsive) begin
                                d.rd_kind = RD_STATUS;
                            end
                        end
                        CMD_RESET: begin
                            if (accept_reset) begin
                                d.state     = ST_BUSY;
                                d.busy_cnt  = RESET_CYCLES - 16'h0001;
                                d.busy_feat = 1'b0;
                                d.ready     = 1'b0;
                                d.rd_kind   = RD_STATUS;
                            end
                        end
                        CMD_READ_ID, CMD_PARAM_PAGE, CMD_SET_FEATURE: begin
                            if (responsive) begin
                                d.state = ST_ADDR;
                            end
                        end
                        CMD_VOLUME_SEL: begin
                            d.state = ST_ADDR;
                        end
                        default: begin
                            d.rd_kind = RD_NONE;
                        end
                    endcase
                end
            end
            ST_ADDR: begin
                if (addr_valid && !sel_n) begin
                    d.state = ST_IDLE;
                    d.ptr   = '0;
                    case (q.cmd)
                        CMD_READ_ID: begin
                            d.rd_kind = (addr_byte == ID_ADDR_SIG) ? RD_ID : RD_NONE;
                        end
                        CMD_PARAM_PAGE: begin
                            d.rd_kind = RD_PARAM;
                        end
                        CMD_SET_FEATURE: begin
                            if (addr_byte == FEAT_ADDR_VOLUME) begin
                                d.state    = ST_FEAT;
                                d.feat_cnt = 2'h0;
                            end
                        end
                        CMD_VOLUME_SEL: begin
                            d.selected = q.appointed && (addr_byte == q.vol);
                        end
                        default: begin
                            d.rd_kind = RD_NONE;
                        end
                    endcase
                end
            end
            ST_FEAT: begin
                if (din_valid && !sel_n) begin
                    if (q.feat_cnt == 2'h0) begin
                        d.new_vol = din_byte;
                    end
                    d.feat_cnt = q.feat_cnt + 2'h1;
                    if (q.feat_cnt == FEAT_LAST_PARAM) begin
                        d.state     = ST_BUSY;
                        d.busy_cnt  = FEATURE_SET_WAIT_CYCLES - 16'h0001;
                        d.busy_feat = 1'b1;
                        d.ready     = 1'b0;
                    end
                end
            end
            ST_BUSY: begin
                if (q.busy_cnt == 16'h0000) begin
                    d.state = ST_IDLE;
                    d.ready = 1'b1;
                    if (q.busy_feat) begin
                        // Chain output rises so the next target in line wakes up.
                        d.vol       = q.new_vol;
                        d.appointed = 1'b1;
                        d.selected  = 1'b0;
                        d.chain_out = 1'b1;
                    end
                end else begin
                    d.busy_cnt = q.busy_cnt - 16'h0001;
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // Reads may poll status even while busy. A deselected or chain-blocked target
        // keeps off the shared data lanes, so only the addressed target answers.
        if (rd_strobe && !sel_n && responsive) begin
            d.dout_vld = 1'b1;
            case (q.rd_kind)
                RD_STATUS: begin
                    d.dout                   = 8'h00;
                    d.dout[STATUS_READY_BIT] = q.ready;
                    d.dout[STATUS_ARDY_BIT]  = q.ready;
                end
                RD_ID: begin
                    case (q.ptr[1:0])
                        2'h0:    d.dout = SIG_BYTE0;
                        2'h1:    d.dout = SIG_BYTE1;
                        2'h2:    d.dout = SIG_BYTE2;
                        default: d.dout = SIG_BYTE3;
                    endcase
                    d.ptr = q.ptr + ROM_AW'(1);
                end
                RD_PARAM: begin
                    d.dout = rom_byte;
                    if (q.ptr != ROM_LAST) begin
                        d.ptr = q.ptr + ROM_AW'(1);
                    end
                end
                default: begin
                    d.dout = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q       <= '0;
            q.state <= ST_IDLE;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Identification and page bytes ride the low lane; the high lane stays zero.
    assign dq_out           = {8'h00, q.dout};
    assign dq_oe            = q.dout_vld;
    assign ready_busy_n     = q.ready;
    assign chain_enable_out = q.chain_out;
    assign vol_selected     = q.selected;
    assign vol_appointed    = q.appointed;
    assign seq_mode         = (q.mode == MODE_SEQ);

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_par_reset_taken: assert property (
        (q.state == ST_IDLE && cmd_valid && !sel_n && cmd_byte == CMD_RESET
         && q.mode != MODE_SEQ && !q.appointed)
        |=> (q.state == ST_BUSY && !ready_busy_n)
        ##(RESET_CYCLES) ready_busy_n)
        else $error("parallel reset not executed for its full time");

    a_seq_reset_gated: assert property (
        (q.state == ST_IDLE && cmd_valid && !sel_n && cmd_byte == CMD_RESET
         && q.mode == MODE_SEQ && !q.appointed && !chain_enable_in)
        |=> q.state == ST_IDLE && ready_busy_n)
        else $error("sequential reset acted without chain input");

    a_seq_mode_entry: assert property (
        (q.mode == MODE_NONE && q.state == ST_IDLE && cmd_valid && !sel_n
         && cmd_byte == CMD_STATUS)
        |=> seq_mode)
        else $error("leading status read did not enter sequential mode");

    a_appoint_chain: assert property (
        (q.state == ST_FEAT && din_valid && !sel_n && q.feat_cnt == FEAT_LAST_PARAM)
        |=> !chain_enable_out [*2] ##(FEATURE_SET_WAIT_CYCLES - 1)
            (chain_enable_out && vol_appointed && !vol_selected))
        else $error("chain output not raised after feature-set wait");

    a_chain_deselect: assert property (
        $rose(chain_enable_out) |-> !vol_selected && $stable(vol_selected))
        else $error("volume selected when chain output rose");

    a_low_lane_only: assert property (
        (rd_strobe && !sel_n && responsive && (q.rd_kind == RD_ID || q.rd_kind == RD_PARAM))
        |=> dq_oe && dq_out[15:8] == 8'h00)
        else $error("data returned outside the low byte");

    a_deselect_quiet: assert property (
        (rd_strobe && !sel_n && !responsive) |=> !dq_oe)
        else $error("deselected target drove read data");

    c_par_reset:  cover property (q.mode == MODE_PAR && q.state == ST_BUSY && !q.busy_feat);
    c_seq_reset:  cover property (q.mode == MODE_SEQ && q.state == ST_BUSY && !q.busy_feat);
    c_appointed:  cover property ($rose(chain_enable_out));
    c_vol_select: cover property ($rose(vol_selected));

endmodule

/* hdl/fdi_pkg.sv */
// Summary of operation
// - Parallel reset accepted by all unappointed sharing targets; appointed ones only while selected
// - Sequential reset acts on unappointed targets only with chain input high; appointed ones only while selected
// - Appointment raises chain output and deselects volume
// - ID and parameter data use low byte only
package fdi_pkg;

    // ========================================================================
    // Command and address codes
    // ========================================================================
    localparam logic [7:0] CMD_RESET        = 8'hFF;
    localparam logic [7:0] CMD_STATUS       = 8'h70;
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_PARAM_PAGE   = 8'hEC;
    localparam logic [7:0] CMD_SET_FEATURE  = 8'hEF;
    localparam logic [7:0] CMD_VOLUME_SEL   = 8'hE1;
    localparam logic [7:0] ID_ADDR_SIG      = 8'h20;
    localparam logic [7:0] FEAT_ADDR_VOLUME = 8'h58;

    // ========================================================================
    // Signature, status and parameter page layout
    // ========================================================================
    localparam logic [7:0] SIG_BYTE0        = 8'h4F;
    localparam logic [7:0] SIG_BYTE1        = 8'h4E;
    localparam logic [7:0] SIG_BYTE2        = 8'h46;
    localparam logic [7:0] SIG_BYTE3        = 8'h49;
    localparam int         STATUS_READY_BIT = 6;
    localparam int         STATUS_ARDY_BIT  = 5;
    localparam int         PAGE_BYTES       = 256;
    localparam int         PAGE_COPIES      = 3;
    localparam int         ROM_DEPTH        = PAGE_BYTES * PAGE_COPIES;
    localparam int         ROM_AW           = 10;
    localparam int         FEATURES_OFFSET  = 6;
    localparam logic [7:0] FEATURES_VALUE   = 8'h00;
    localparam logic [1:0] FEAT_LAST_PARAM  = 2'h3;
    localparam logic [ROM_AW-1:0] ROM_LAST  = ROM_AW'(ROM_DEPTH - 1);

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int          CLK_PERIOD_NS               = 10;
    localparam int          RESET_TIME_NS               = 1000;
    localparam int          FEATURE_SET_WAIT_TIME_NS    = 1000;
    localparam logic [15:0] RESET_CYCLES                =
        16'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] FEATURE_SET_WAIT_CYCLES     =
        16'((FEATURE_SET_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_FEAT = 4'h4,
        ST_BUSY = 4'h8
    } fdi_state_t;

    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_PAR  = 2'h1,
        MODE_SEQ  = 2'h2
    } fdi_mode_t;

    typedef enum logic [1:0] {
        RD_NONE   = 2'h0,
        RD_STATUS = 2'h1,
        RD_ID     = 2'h2,
        RD_PARAM  = 2'h3
    } fdi_rd_t;

    typedef struct packed {
        fdi_state_t       state;
        fdi_mode_t        mode;
        fdi_rd_t          rd_kind;
        logic [7:0]       cmd;
        logic [15:0]      busy_cnt;
        logic             busy_feat;
        logic [ROM_AW-1:0] ptr;
        logic [1:0]       feat_cnt;
        logic [7:0]       new_vol;
        logic [7:0]       vol;
        logic             appointed;
        logic             selected;
        logic             chain_out;
        logic             ready;
        logic [7:0]       dout;
        logic             dout_vld;
    } fdi_regs_t;

endpackage

/* hdl/fdi_param_rom.sv */
`timescale 1ns/1ps
module fdi_param_rom
    import fdi_pkg::*;
(
    // Byte index across all page copies
    input  wire logic [ROM_AW-1:0] idx,
    // Addressed byte
    output logic [7:0]             data
);

    // ========================================================================
    // Page copies
    // ========================================================================
    logic [7:0] mem [ROM_DEPTH];

    // Every copy carries the signature so the host can count the copies.
    for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_byte
        localparam int OFS = i % PAGE_BYTES;
        assign mem[i] = (OFS == 0) ? SIG_BYTE0 :
                        (OFS == 1) ? SIG_BYTE1 :
                        (OFS == 2) ? SIG_BYTE2 :
                        (OFS == 3) ? SIG_BYTE3 :
                        (OFS == FEATURES_OFFSET) ? FEATURES_VALUE : 8'h00;
    end

    // Indices past the last copy read as zero, ending the copy scan.
    assign data = (int'(idx) < ROM_DEPTH) ? mem[idx] : 8'h00;

endmodule

/* testbench/fdi_host_model.sv */
`timescale 1ns/1ps
module fdi_host_model
    import fdi_pkg::*;
#(
    parameter int SELECT_SETUP_CYCLES = 2
)
(
    // Clock
    input  wire logic       clk,
    // Select and strobes towards the targets
    output logic            sel_n,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            addr_valid,
    output logic [7:0]      addr_byte,
    output logic            din_valid,
    output logic [7:0]      din_byte,
    output logic            rd_strobe
);
    // =========================================================
    // Idle levels
    // =========================================================
    initial begin
        sel_n      = 1'b1;
        cmd_valid  = 1'b0;
        cmd_byte   = 8'h00;
        addr_valid = 1'b0;
        addr_byte  = 8'h00;
        din_valid  = 1'b0;
        din_byte   = 8'h00;
        rd_strobe  = 1'b0;
    end

    // =========================================================
    // Bus cycles
    // =========================================================
    // A new falling select waits the slow setup time before any strobe.
    task automatic select(input logic level);
        @(posedge clk);
        sel_n <= level;
        repeat (SELECT_SETUP_CYCLES) @(posedge clk);
    endtask

    // Bytes are inverted on release so a stale value never passes as fresh.
    task automatic send_cmd(input logic [7:0] code);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= code;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~code;
    endtask

    task automatic send_addr(input logic [7:0] addr);
        @(posedge clk);
        addr_valid <= 1'b1;
        addr_byte  <= addr;
        @(posedge clk);
        addr_valid <= 1'b0;
        addr_byte  <= ~addr;
    endtask

    task automatic send_din(input logic [7:0] data);
        @(posedge clk);
        din_valid <= 1'b1;
        din_byte  <= data;
        @(posedge clk);
        din_valid <= 1'b0;
        din_byte  <= ~data;
    endtask

    // Returns just after the edge that registers the answer.
    task automatic pulse_read();
        @(posedge clk);
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
    endtask

    task automatic appoint(input logic [7:0] vol);
        send_cmd(CMD_SET_FEATURE);
        send_addr(FEAT_ADDR_VOLUME);
        send_din(vol);
        repeat (3) send_din(8'h00);
    endtask
endmodule

/* testbench/flash_target_discovery_init_tb.sv */
`timescale 1ns/1ps
module flash_target_discovery_init_tb
    import fdi_pkg::*;
;
    localparam logic [7:0] SIG [4] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2, SIG_BYTE3};

    logic        clk;
    logic        rst_b;
    logic        chain_head;
    logic        sel_n;
    logic        cmd_valid;
    logic [7:0]  cmd_byte;
    logic        addr_valid;
    logic [7:0]  addr_byte;
    logic        din_valid;
    logic [7:0]  din_byte;
    logic        rd_strobe;
    logic [15:0] dq_a;
    logic [15:0] dq_b;
    logic        oe_a;
    logic        oe_b;
    logic        rb_a;
    logic        rb_b;
    logic        ce_a;
    logic        ce_b;
    logic        vs_a;
    logic        vs_b;
    logic        va_a;
    logic        va_b;
    logic        sm_a;
    logic        sm_b;
    int          errors;
    int          total_checks;

    always #5 clk = ~clk;

    fdi_host_model u_host (.clk, .sel_n, .cmd_valid, .cmd_byte, .addr_valid, .addr_byte,
        .din_valid, .din_byte, .rd_strobe);

    fdi_target u_dut (.clk, .rst_b, .sel_n, .chain_enable_in(chain_head), .cmd_valid, .cmd_byte,
        .addr_valid, .addr_byte, .din_valid, .din_byte, .rd_strobe, .dq_out(dq_a),
        .dq_oe(oe_a), .ready_busy_n(rb_a), .chain_enable_out(ce_a), .vol_selected(vs_a),
        .vol_appointed(va_a), .seq_mode(sm_a));

    fdi_target u_dut_b (.clk, .rst_b, .sel_n, .chain_enable_in(ce_a), .cmd_valid, .cmd_byte,
        .addr_valid, .addr_byte, .din_valid, .din_byte, .rd_strobe, .dq_out(dq_b),
        .dq_oe(oe_b), .ready_busy_n(rb_b), .chain_enable_out(ce_b), .vol_selected(vs_b),
        .vol_appointed(va_b), .seq_mode(sm_b));

    // =========================================================
    // Shared tasks
    // =========================================================
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask

    function automatic logic [7:0] page_byte(input int ofs);
        page_byte = (ofs == FEATURES_OFFSET) ? FEATURES_VALUE : 8'h00;
        if (ofs < 4) begin
            page_byte = SIG[ofs];
        end
    endfunction

    task automatic summarize();
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apply_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask

    // Bounded so a target stuck in busy ends the run instead of hanging it.
    task automatic wait_ready(output int n);
        n = 0;
        while (!(rb_a === 1'b1 && rb_b === 1'b1)) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 400) begin
                errors++;
                summarize();
            end
        end
    endtask

    // The wait starts one edge after the command edge, so it counts one cycle short.
    task automatic busy_then_ready(input logic [1:0] exp_rb, input int cyc);
        int n;
        @(posedge clk);
        #1;
        check(24'({rb_a, rb_b}), 24'(exp_rb));
        wait_ready(n);
        check(24'(n), 24'(cyc - 1));
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic sc_reset_values();
        #1;
        check(24'({oe_a, rb_a, ce_a, vs_a, va_a, sm_a, dq_a}), 24'h100000);
        check(24'({oe_b, rb_b, ce_b, vs_b, va_b, sm_b, dq_b}), 24'h100000);
    endtask

    task automatic sc_sequential();
        u_host.select(1'b0);
        u_host.send_cmd(CMD_STATUS);
        #1;
        check(24'({sm_a, sm_b}), 24'h3);
        u_host.send_cmd(CMD_RESET);
        @(posedge clk);
        #1;
        check(24'({rb_a, rb_b}), 24'h3);
        @(posedge clk);
        chain_head <= 1'b1;
        u_host.send_cmd(CMD_RESET);
        busy_then_ready(2'b01, RESET_CYCLES);
        u_host.send_cmd(CMD_STATUS);
        u_host.pulse_read();
        check(24'({oe_a, dq_a[STATUS_READY_BIT]}), 24'h3);
        u_host.send_cmd(CMD_READ_ID);
        u_host.send_addr(ID_ADDR_SIG);
        for (int i = 0; i < 4; i++) begin
            u_host.pulse_read();
            check(24'({oe_a, dq_a}), {8'h01, 8'h00, SIG[i]});
        end
        u_host.appoint(8'h01);
        busy_then_ready(2'b01, FEATURE_SET_WAIT_CYCLES);
        check(24'({ce_a, va_a, vs_a}), 24'h6);
        u_host.send_cmd(CMD_RESET);
        busy_then_ready(2'b10, RESET_CYCLES);
        u_host.send_cmd(CMD_READ_ID);
        u_host.send_addr(ID_ADDR_SIG);
        u_host.pulse_read();
        check(24'({oe_a, oe_b, dq_b}), {8'h01, 8'h00, SIG[0]});
        u_host.appoint(8'h02);
        busy_then_ready(2'b10, FEATURE_SET_WAIT_CYCLES);
        check(24'({ce_b, va_b, vs_b}), 24'h6);
        u_host.select(1'b1);
        u_host.select(1'b0);
        for (int v = 1; v <= 2; v++) begin
            u_host.send_cmd(CMD_VOLUME_SEL);
            u_host.send_addr(8'(v));
            @(posedge clk);
            #1;
            check(24'({vs_a, vs_b}), 24'(3 - v));
        end
    endtask

    task automatic sc_parallel();
        logic [7:0] exp;
        logic [7:0] vote;
        logic [7:0] pg [PAGE_COPIES][PAGE_BYTES];
        apply_reset();
        sc_reset_values();
        u_host.select(1'b1);
        u_host.send_cmd(CMD_STATUS);
        u_host.select(1'b0);
        u_host.send_cmd(CMD_RESET);
        #1;
        check(24'({sm_a, sm_b}), 24'h0);
        busy_then_ready(2'b00, RESET_CYCLES);
        u_host.send_cmd(CMD_READ_ID);
        u_host.send_addr(8'h00);
        u_host.pulse_read();
        check(24'({oe_a, dq_a}), 24'h010000);
        u_host.send_cmd(CMD_PARAM_PAGE);
        u_host.send_addr(8'h00);
        // Reads past the last copy find no signature, which ends the copy scan.
        for (int i = 0; i < ROM_DEPTH + 4; i++) begin
            u_host.pulse_read();
            exp = (i < ROM_DEPTH) ? page_byte(i % PAGE_BYTES) : 8'h00;
            check(24'({oe_a, dq_a}), {8'h01, 8'h00, exp});
            if (i < ROM_DEPTH) begin
                pg[i / PAGE_BYTES][i % PAGE_BYTES] = dq_a[7:0];
            end
        end
        for (int j = 0; j < PAGE_BYTES; j++) begin
            vote = (pg[0][j] & pg[1][j]) | (pg[0][j] & pg[2][j]) | (pg[1][j] & pg[2][j]);
            check(24'(vote), 24'(page_byte(j)));
        end
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        chain_head = 1'b0;
        errors = 0;
        total_checks = 0;
        apply_reset();
        sc_reset_values();
        sc_sequential();
        sc_parallel();
        summarize();
    end
endmodule
